// file: design/exc_event_regs.svh
// Register map constants for the exception event register set
`ifndef EXC_EVENT_REGS_SVH
`define EXC_EVENT_REGS_SVH
`define ADDR_TRAP_IMMEDIATE   32'hFF000020
`define ADDR_EXCEPTION_CAUSE  32'hFF000024
`define ADDR_INTERRUPT_CAUSE  32'hFF000028
`define ALIAS_IGNORE_BITS     3
`define ADDR_MATCH_MASK       32'h1FFFFFFF
`define EXC_CODE_W            12
`define INT_CODE_W            14
`define TRAP_IMM_W            8
`define TRAP_IMM_LSB          2
`define EXC_RESET_POWERON     12'h000
`define EXC_RESET_MANUAL      12'h020
`define REG_INDEX_W           2
`endif

// file: design/exc_event_pkg.sv
// Types shared by the exception event register set
package exc_event_pkg;
   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_TRAP,
      SEL_EXC,
      SEL_INT
   } reg_sel_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_t;
endpackage

// file: design/exc_code_store.sv
// Small register store for one hardware-loaded, software-writable code
`timescale 1ns/1ps
module exc_code_store #(
   parameter int W = 12
) (
   input  wire logic         clk,
   input  wire logic         hw_load,
   input  wire logic [W-1:0] hw_code,
   input  wire logic         sw_load,
   input  wire logic [W-1:0] sw_code,
   output logic      [W-1:0] rdata
);
   logic [W-1:0] data_q;
   logic [W-1:0] data_d;

   // Hardware capture wins over a software write in the same cycle
   always_comb begin
      data_d = data_q;
      if (hw_load) begin
         data_d = hw_code;
      end else if (sw_load) begin
         data_d = sw_code;
      end
   end

   // No reset: contents undefined until first load
   always_ff @(posedge clk) begin
      data_q <= data_d;
   end

   assign rdata = data_q;
endmodule

// file: design/exception_event_registers.sv
// Exception, interrupt and trap cause registers on the control space
`timescale 1ns/1ps
`include "exc_event_regs.svh"
// Function
// [RULE1] Exception cause at FF000024, alias 1F000024, 32-bit read/write.
// [RULE2] Exception cause resets to zero on power-on, 0x20 on manual reset.
// [RULE3] Exception cause holds 12-bit code, loaded on reset or general exception.
// [RULE4] Software write replaces exception cause until next hardware exception.
// [RULE5] Interrupt cause at FF000028 with alias, holds 14-bit code on interrupt.
// [RULE6] Interrupt cause accepts software writes; no reset value needed.
// [RULE7] Trap immediate at FF000020 stores 8-bit immediate in bits 9..2.
// [RULE8] Trap immediate accepts software writes; reset contents undefined.
// [RULE9] Reserved bits read zero; software writes only zero there.
// [RULE10] Upper three address bits ignored so both aliases decode alike.
// [RULE11] Exception code written to bits 11..0 before handler branch.
// [RULE12] Hardware capture beats software write in the same cycle.
module exception_event_registers (
   input  wire logic                     CLK,
   input  wire logic                     RESET_N,
   input  wire logic                     MANUAL_RESET,
   input  wire exc_event_pkg::bus_req_t  REQ,
   input  wire logic                     EXC_TAKEN,
   input  wire logic [11:0]              EXC_CODE,
   input  wire logic                     INT_TAKEN,
   input  wire logic [13:0]              INT_CODE,
   input  wire logic                     TRAP_TAKEN,
   input  wire logic [7:0]               TRAP_IMM,
   output logic                          ACK,
   output logic                          HIT,
   output logic [31:0]                   RDATA
);
   exc_event_pkg::reg_sel_t sel;
   logic [11:0]             exc_q;
   logic [11:0]             exc_d;
   logic [13:0]             int_rd;
   logic [7:0]              trap_rd;
   logic                    ack_q;
   logic                    ack_d;
   logic                    hit_q;
   logic                    hit_d;
   logic [31:0]             rdata_q;
   logic [31:0]             rdata_d;
   logic                    manual_q;
   logic                    manual_d;
   logic                    sw_exc;
   logic                    sw_int;
   logic                    sw_trap;

   // One masked compare per register serves both aliases
   // [RULE10] alias address folding
   function automatic exc_event_pkg::reg_sel_t decode(input logic [31:0] a);
      logic [31:0] m;
      m = a & `ADDR_MATCH_MASK;
      if (m == (`ADDR_TRAP_IMMEDIATE & `ADDR_MATCH_MASK)) begin
         return exc_event_pkg::SEL_TRAP;
      end else if (m == (`ADDR_EXCEPTION_CAUSE & `ADDR_MATCH_MASK)) begin
         return exc_event_pkg::SEL_EXC;
      end else if (m == (`ADDR_INTERRUPT_CAUSE & `ADDR_MATCH_MASK)) begin
         return exc_event_pkg::SEL_INT;
      end
      return exc_event_pkg::SEL_NONE;
   endfunction

   // [RULE10] decode both aliases
   assign sel     = decode(REQ.addr);
   assign sw_exc  = REQ.valid && REQ.write && (sel == exc_event_pkg::SEL_EXC);
   assign sw_int  = REQ.valid && REQ.write && (sel == exc_event_pkg::SEL_INT);
   assign sw_trap = REQ.valid && REQ.write && (sel == exc_event_pkg::SEL_TRAP);

   // [RULE5] interrupt code store
   exc_code_store #(
      .W (`INT_CODE_W)
   ) u_int_store (
      .clk     (CLK),
      .hw_load (INT_TAKEN),
      .hw_code (INT_CODE),
      .sw_load (sw_int),
      .sw_code (REQ.wdata[`INT_CODE_W-1:0]),
      .rdata   (int_rd)
   );

   // [RULE7] trap immediate store
   exc_code_store #(
      .W (`TRAP_IMM_W)
   ) u_trap_store (
      .clk     (CLK),
      .hw_load (TRAP_TAKEN),
      .hw_code (TRAP_IMM),
      .sw_load (sw_trap),
      .sw_code (REQ.wdata[`TRAP_IMM_LSB +: `TRAP_IMM_W]),
      .rdata   (trap_rd)
   );

   // Manual reset request is synchronous: it loads the manual code
   always_comb begin
      manual_d = MANUAL_RESET;
      exc_d    = exc_q;
      // [RULE2] manual reset code
      if (manual_q) begin
         exc_d = `EXC_RESET_MANUAL;
      // [RULE12] hardware wins
      end else if (EXC_TAKEN) begin
         // [RULE11] code into bits 11..0
         exc_d = EXC_CODE;
      end else if (sw_exc) begin
         // [RULE4] software overwrite
         exc_d = REQ.wdata[`EXC_CODE_W-1:0];
      end
   end

   // Read mux; reserved bits forced to zero
   // Writes answer zero so write data never looks like a read
   always_comb begin
      ack_d   = REQ.valid;
      hit_d   = REQ.valid && (sel != exc_event_pkg::SEL_NONE);
      rdata_d = 32'h00000000;
      if (REQ.valid && !REQ.write) begin
         unique case (sel)
            // [RULE9] zero reserved bits
            exc_event_pkg::SEL_TRAP: rdata_d = {22'h000000, trap_rd, 2'h0};
            exc_event_pkg::SEL_EXC:  rdata_d = {20'h00000, exc_q};
            exc_event_pkg::SEL_INT:  rdata_d = {18'h00000, int_rd};
            exc_event_pkg::SEL_NONE: rdata_d = 32'h00000000;
         endcase
      end
   end

   // [RULE2] power-on reset value
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         exc_q    <= `EXC_RESET_POWERON;
         manual_q <= 1'h0;
      end else begin
         exc_q    <= exc_d;
         manual_q <= manual_d;
      end
   end

   // Response flops keep every output glitch-free
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ack_q   <= 1'h0;
         hit_q   <= 1'h0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q   <= ack_d;
         hit_q   <= hit_d;
         rdata_q <= rdata_d;
      end
   end

   assign ACK   = ack_q;
   assign HIT   = hit_q;
   assign RDATA = rdata_q;

   // Assertions
   exc_capture_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE3]
      (EXC_TAKEN && !manual_q) |=> (exc_q == $past(EXC_CODE)))
      else $error("exception code not captured");

   exc_manual_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE2]
      manual_q |=> (exc_q == `EXC_RESET_MANUAL))
      else $error("manual reset code wrong");

   exc_swwrite_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE4]
      (sw_exc && !EXC_TAKEN && !manual_q) |=> (exc_q == $past(REQ.wdata[11:0])))
      else $error("software write lost");

   exc_hwwins_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE12]
      (sw_exc && EXC_TAKEN && !manual_q && (REQ.wdata[11:0] != EXC_CODE))
      |=> (exc_q != $past(REQ.wdata[11:0])))
      else $error("software beat hardware");

   int_readback_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE5]
      (INT_TAKEN ##1 (REQ.valid && !REQ.write && sel == exc_event_pkg::SEL_INT && !INT_TAKEN && !sw_int))
      |=> (RDATA == {18'h00000, $past(INT_CODE, 2)}))
      else $error("interrupt code readback wrong");

   trap_readback_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE7]
      (TRAP_TAKEN ##1 (REQ.valid && !REQ.write && sel == exc_event_pkg::SEL_TRAP && !TRAP_TAKEN && !sw_trap))
      |=> (RDATA == {22'h000000, $past(TRAP_IMM, 2), 2'h0}))
      else $error("trap immediate readback wrong");

   reserved_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE9]
      $past(REQ.valid && !REQ.write && sel == exc_event_pkg::SEL_EXC) |-> (RDATA[31:12] == 20'h00000))
      else $error("reserved bits not zero");

   alias_hit_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE10]
      (REQ.valid && (REQ.addr == (`ADDR_EXCEPTION_CAUSE & `ADDR_MATCH_MASK))) |=> HIT)
      else $error("alias address missed");

   ack_once_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      REQ.valid |=> ACK)
      else $error("access not acknowledged");

   exc_read_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      (REQ.valid && !REQ.write && REQ.addr == `ADDR_EXCEPTION_CAUSE) |=> (RDATA[11:0] == $past(exc_q)))
      else $error("exception cause readback wrong");

   cov_exc_c:   cover property (@(posedge CLK) disable iff (!RESET_N) EXC_TAKEN ##1 sw_exc);
   cov_clash_c: cover property (@(posedge CLK) disable iff (!RESET_N) EXC_TAKEN && sw_exc);
   cov_alias_c: cover property (@(posedge CLK) disable iff (!RESET_N)
      REQ.valid && REQ.addr == (`ADDR_INTERRUPT_CAUSE & `ADDR_MATCH_MASK));
   cov_manual_c: cover property (@(posedge CLK) disable iff (!RESET_N) manual_q);
   cov_trap_c:   cover property (@(posedge CLK) disable iff (!RESET_N)
      TRAP_TAKEN ##1 (REQ.valid && (sel == exc_event_pkg::SEL_TRAP)));

   // Idle bus keeps every response low
   ack_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      !REQ.valid
      |=> !ACK)
      else $error("acknowledge without request");

   hit_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      !REQ.valid
      |=> !HIT)
      else $error("hit without request");

   rdata_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE9]
      !REQ.valid
      |=> (RDATA == 32'h00000000))
      else $error("read data not cleared");

   ack_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      ACK
      |-> $past(REQ.valid))
      else $error("acknowledge not caused by request");

   hit_ack_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      HIT
      |-> ACK)
      else $error("hit without acknowledge");

   exc_hit_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      (REQ.valid && (REQ.addr == `ADDR_EXCEPTION_CAUSE))
      |=> HIT)
      else $error("exception cause address missed");

   unmapped_miss_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE1]
      (REQ.valid && (sel == exc_event_pkg::SEL_NONE))
      |=> (!HIT && (RDATA == 32'h00000000)))
      else $error("unmapped address answered");

   write_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE4]
      (REQ.valid && REQ.write)
      |=> (RDATA == 32'h00000000))
      else $error("write returned data");

   // Register contents hold and capture
   exc_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE4]
      (!manual_q && !EXC_TAKEN && !sw_exc)
      |=> $stable(exc_q))
      else $error("exception cause changed unasked");

   manual_load_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE2]
      MANUAL_RESET
      |-> ##2 (exc_q == `EXC_RESET_MANUAL))
      else $error("manual reset code not loaded");

   int_hwwins_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE12]
      INT_TAKEN
      |=> (int_rd == $past(INT_CODE)))
      else $error("interrupt code not captured");

   trap_hwwins_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE12]
      TRAP_TAKEN
      |=> (trap_rd == $past(TRAP_IMM)))
      else $error("trap immediate not captured");

   int_swwrite_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE6]
      (sw_int && !INT_TAKEN)
      |=> (int_rd == $past(REQ.wdata[`INT_CODE_W-1:0])))
      else $error("interrupt cause write lost");

   trap_swwrite_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE8]
      (sw_trap && !TRAP_TAKEN)
      |=> (trap_rd == $past(REQ.wdata[`TRAP_IMM_LSB +: `TRAP_IMM_W])))
      else $error("trap immediate write lost");

   // Aliases and reserved fields
   int_alias_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE10]
      (REQ.valid && (REQ.addr == (`ADDR_INTERRUPT_CAUSE & `ADDR_MATCH_MASK)))
      |=> HIT)
      else $error("interrupt alias missed");

   trap_alias_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE10]
      (REQ.valid && (REQ.addr == (`ADDR_TRAP_IMMEDIATE & `ADDR_MATCH_MASK)))
      |=> HIT)
      else $error("trap alias missed");

   alias_read_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE10]
      (REQ.valid && !REQ.write && (REQ.addr == (`ADDR_EXCEPTION_CAUSE & `ADDR_MATCH_MASK)))
      |=> (RDATA[`EXC_CODE_W-1:0] == $past(exc_q)))
      else $error("alias readback wrong");

   trap_low_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE7]
      (REQ.valid && !REQ.write && (sel == exc_event_pkg::SEL_TRAP))
      |=> (RDATA[`TRAP_IMM_LSB-1:0] == 2'h0))
      else $error("trap low bits not zero");

   int_reserved_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE9]
      (REQ.valid && !REQ.write && (sel == exc_event_pkg::SEL_INT))
      |=> (RDATA[31:`INT_CODE_W] == 18'h00000))
      else $error("interrupt reserved bits not zero");
endmodule

// file: sim/tb.sv
// Self-checking bench for the exception event register set
`timescale 1ns/1ps
`include "exc_event_regs.svh"
module tb;
   logic                    CLK;
   logic                    RESET_N;
   logic                    MANUAL_RESET;
   exc_event_pkg::bus_req_t REQ;
   logic                    EXC_TAKEN;
   logic [11:0]             EXC_CODE;
   logic                    INT_TAKEN;
   logic [13:0]             INT_CODE;
   logic                    TRAP_TAKEN;
   logic [7:0]              TRAP_IMM;
   logic                    ACK;
   logic                    HIT;
   logic [31:0]             RDATA;
   int                      fail_count;
   int                      checked;
   localparam logic [31:0]  EXC_A = `ADDR_EXCEPTION_CAUSE;
   localparam logic [31:0]  INT_A = `ADDR_INTERRUPT_CAUSE;
   localparam logic [31:0]  TRP_A = `ADDR_TRAP_IMMEDIATE;
   localparam logic [31:0]  MSK   = `ADDR_MATCH_MASK;

   exception_event_registers dut_u (
      .CLK(CLK), .RESET_N(RESET_N), .MANUAL_RESET(MANUAL_RESET), .REQ(REQ),
      .EXC_TAKEN(EXC_TAKEN), .EXC_CODE(EXC_CODE), .INT_TAKEN(INT_TAKEN), .INT_CODE(INT_CODE),
      .TRAP_TAKEN(TRAP_TAKEN), .TRAP_IMM(TRAP_IMM), .ACK(ACK), .HIT(HIT), .RDATA(RDATA)
   );

   initial CLK = 1'h0;
   always #5 CLK = ~CLK;

   task automatic tally_and_finish();
      if (fail_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Entered at a falling edge; strobe spans exactly one rising edge
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] exp_rd, input logic exp_hit);
      int n;
      REQ = '{valid: 1'h1, write: w, addr: a, wdata: d};
      @(negedge CLK);
      REQ.valid = 1'h0;
      n = 0;
      while (ACK !== 1'h1 && n < 4) begin
         @(negedge CLK);
         n++;
      end
      if (n == 4) begin
         fail_count++;
         tally_and_finish();
      end else begin
         chk("hit", {31'h0, HIT}, {31'h0, exp_hit});
         chk("rdata", RDATA, exp_rd);
         // One idle edge keeps strobes of back-to-back calls apart
         @(negedge CLK);
         chk("ack idle", {31'h0, ACK}, 32'h00000000);
         chk("hit idle", {31'h0, HIT}, 32'h00000000);
      end
   endtask

   // One-cycle hardware event; k selects trap, interrupt, exception
   task automatic ev(input logic [2:0] k, input logic [13:0] code);
      {TRAP_TAKEN, INT_TAKEN, EXC_TAKEN} = k;
      EXC_CODE = code[11:0];
      INT_CODE = code;
      TRAP_IMM = code[7:0];
      @(negedge CLK);
      {TRAP_TAKEN, INT_TAKEN, EXC_TAKEN} = 3'h0;
   endtask

   initial begin
      fail_count = 0;
      checked = 0;
      RESET_N = 1'h0;
      MANUAL_RESET = 1'h0;
      REQ = '0;
      EXC_TAKEN = 1'h0;
      EXC_CODE = 12'h000;
      INT_TAKEN = 1'h0;
      INT_CODE = 14'h0000;
      TRAP_TAKEN = 1'h0;
      TRAP_IMM = 8'h00;
      repeat (3) @(negedge CLK);
      RESET_N = 1'h1;
      @(negedge CLK);
      acc(1'h0, EXC_A, 32'h0, 32'h0, 1'h1);
      acc(1'h1, EXC_A, 32'h00000ABC, 32'h0, 1'h1);
      acc(1'h0, EXC_A & MSK, 32'h0, 32'h00000ABC, 1'h1);
      ev(3'h1, 14'h0160);
      acc(1'h0, EXC_A, 32'h0, 32'h00000160, 1'h1);
      ev(3'h2, 14'h3A5C);
      acc(1'h0, INT_A & MSK, 32'h0, 32'h00003A5C, 1'h1);
      acc(1'h1, INT_A, 32'h00001234, 32'h0, 1'h1);
      acc(1'h0, INT_A, 32'h0, 32'h00001234, 1'h1);
      ev(3'h4, 14'h00C3);
      acc(1'h0, TRP_A, 32'h0, 32'h0000030C, 1'h1);
      acc(1'h1, TRP_A & MSK, 32'h000003FC, 32'h0, 1'h1);
      acc(1'h0, TRP_A, 32'h0, 32'h000003FC, 1'h1);
      // Same edge: event code must survive the write
      EXC_TAKEN = 1'h1;
      EXC_CODE = 12'h0E0;
      acc(1'h1, EXC_A, 32'h00000555, 32'h0, 1'h1);
      EXC_TAKEN = 1'h0;
      acc(1'h0, EXC_A, 32'h0, 32'h000000E0, 1'h1);
      acc(1'h0, 32'hFF00002C, 32'h0, 32'h0, 1'h0);
      MANUAL_RESET = 1'h1;
      @(negedge CLK);
      MANUAL_RESET = 1'h0;
      @(negedge CLK);
      acc(1'h0, EXC_A, 32'h0, 32'h00000020, 1'h1);
      RESET_N = 1'h0;
      @(negedge CLK);
      RESET_N = 1'h1;
      @(negedge CLK);
      acc(1'h0, EXC_A & MSK, 32'h0, 32'h0, 1'h1);
      tally_and_finish();
   end
endmodule
